/* File: rtl/fecp_top.sv */
`timescale 1ns/1ps
module fecp_top #(
  parameter int RX_OVS = fecp_pkg::RX_OVS_DEF
) (
  // system
  input wire logic CLK_SYS,
  input wire logic RESET,
  // speed selection
  input wire logic [1:0] SPEED,
  // mac transmit
  input wire logic TX_EN,
  input wire logic TX_ER,
  input wire logic [3:0] TXD,
  output logic TX_NIB_TAKE,
  // line transmit
  input wire logic TX_LINE_CLK,
  output logic TX_LINE_POS,
  output logic TX_LINE_NEG,
  // line receive
  input wire logic RX_LINE_POS,
  input wire logic RX_LINE_NEG,
  input wire logic SQUELCH_LVL,
  // mac receive
  output logic RX_CLK,
  output logic [3:0] RXD,
  output logic RX_DV,
  output logic RX_ER,
  output logic RX_POL_INV,
  // gigabit analog stages
  output logic ECHO_CANCEL_EN,
  output logic ADC_EN
);
  import fecp_pkg::*;

  localparam logic [7:0] OVS_MID = 8'(RX_OVS / 2);
  localparam logic [7:0] OVS_LAST = 8'(RX_OVS - 1);
  localparam logic [7:0] RCK_HALF_100 = 8'((RX_OVS * SYM_BITS) / 2 - 1);
  localparam logic [7:0] RCK_HALF_10 = 8'(T10_NIB_HALF_CYC - 1);
  localparam logic [7:0] MAN_GATE = 8'(MAN_GATE_CYC);
  localparam logic [7:0] MAN_LOSS = 8'(MAN_LOSS_CYC);
  localparam logic [7:0] SQ_MIN_PW = 8'(SQ_MIN_PW_CYC);
  localparam logic [2:0] SYM_LAST = 3'(SYM_BITS - 1);
  localparam logic [7:0] R10_FLUSH = 8'(T10_NIB_HALF_CYC * 2 - 1);

  logic mode_10;
  logic mode_100;
  assign mode_10 = (SPEED == SPEED_10);
  assign mode_100 = (SPEED == SPEED_100);

  // transmit, 100BASE-TX
  logic [2:0] txc_q;
  logic tx_bit_stb;
  logic tx_sym_end;
  logic tx_take;
  logic tx_key;
  logic tx_sbit;
  logic tx_nrzi_q;
  logic tx_nrzi_d;
  logic [1:0] tx_mlt_q;
  logic [1:0] tx_mlt_d;
  logic [2:0] tx_cnt_q;
  logic [4:0] tx_sym_q;
  logic [4:0] tx_next;
  logic tx_pos_q;
  logic tx_neg_q;
  fecp_tx_st_t tx_st_q;
  fecp_tx_st_t tx_st_d;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      txc_q <= 3'h0;
    else
      txc_q <= {txc_q[1:0], TX_LINE_CLK};
  end

  assign tx_bit_stb = mode_100 & txc_q[1] & ~txc_q[2];
  assign tx_sym_end = tx_bit_stb & (tx_cnt_q == SYM_LAST);
  assign tx_sbit = tx_sym_q[4] ^ tx_key;
  assign tx_nrzi_d = tx_nrzi_q ^ tx_sbit;
  assign tx_mlt_d = tx_mlt_q + {1'b0, tx_nrzi_d ^ tx_nrzi_q};
  assign TX_NIB_TAKE = tx_sym_end & tx_take;

  // J/K stand in for the first preamble byte, T/R close the stream
  always_comb
  begin
    tx_st_d = tx_st_q;
    tx_next = SYM_I;
    tx_take = 1'b0;
    case (tx_st_q)
      TX_IDLE:
        if (TX_EN)
        begin
          tx_next = SYM_J;
          tx_take = 1'b1;
          tx_st_d = TX_SK;
        end
      TX_SK:
      begin
        tx_next = SYM_K;
        tx_take = 1'b1;
        tx_st_d = TX_DATA;
      end
      TX_DATA:
        if (TX_EN)
        begin
          tx_next = TX_ER ? SYM_H : fecp_enc(TXD);
          tx_take = 1'b1;
        end
        else
        begin
          tx_next = SYM_T;
          tx_st_d = TX_END;
        end
      TX_END:
      begin
        tx_next = SYM_R;
        tx_st_d = TX_IDLE;
      end
      default:
        tx_st_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 3'h0;
      tx_sym_q <= SYM_I;
    end
    else if (!mode_100)
    begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 3'h0;
      tx_sym_q <= SYM_I;
    end
    else if (tx_sym_end)
    begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= 3'h0;
      tx_sym_q <= tx_next;
    end
    else if (tx_bit_stb)
    begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
      tx_sym_q <= {tx_sym_q[3:0], 1'b0};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      tx_nrzi_q <= 1'b0;
      tx_mlt_q <= 2'h0;
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
    end
    else if (!mode_100)
    begin
      tx_mlt_q <= 2'h0;
      tx_pos_q <= 1'b0;
      tx_neg_q <= 1'b0;
    end
    else if (tx_bit_stb)
    begin
      tx_nrzi_q <= tx_nrzi_d;
      tx_mlt_q <= tx_mlt_d;
      tx_pos_q <= (tx_mlt_d == 2'h1);
      tx_neg_q <= (tx_mlt_d == 2'h3);
    end
  end

  fecp_lfsr u_tx_scr (
    .clk(CLK_SYS),
    .rst(RESET),
    .adv(tx_bit_stb),
    .load(1'b0),
    .load_bit(1'b0),
    .key(tx_key)
  );

  assign TX_LINE_POS = tx_pos_q;
  assign TX_LINE_NEG = tx_neg_q;

  // receive pin synchronisers
  logic [1:0] rxp_q;
  logic [1:0] rxn_q;
  logic [1:0] sq_q;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      rxp_q <= 2'h0;
      rxn_q <= 2'h0;
      sq_q <= 2'h0;
    end
    else
    begin
      rxp_q <= {rxp_q[0], RX_LINE_POS};
      rxn_q <= {rxn_q[0], RX_LINE_NEG};
      sq_q <= {sq_q[0], SQUELCH_LVL};
    end
  end

  // receive, 100BASE-TX
  logic [1:0] r_lvl_q;
  logic r_chg;
  logic r_nrzi_q;
  logic r_samp_q;
  logic [7:0] r_ph_q;
  logic r_bit_stb;
  logic r_nrz;
  logic r_key;
  logic r_plain;
  logic r_lock_q;
  logic [5:0] r_lcnt_q;
  logic [9:0] r_sh_q;
  logic [9:0] r_sh_d;
  logic r_al_q;
  logic [2:0] r_c5_q;
  logic r_sym_done;
  logic r_end;
  logic [4:0] r_dec;
  logic n100_stb;

  assign r_chg = ({rxp_q[1], rxn_q[1]} != r_lvl_q);
  assign r_bit_stb = mode_100 & (r_ph_q == OVS_MID);
  assign r_nrz = r_nrzi_q ^ r_samp_q;
  assign r_plain = r_nrz ^ r_key;
  assign r_sh_d = {r_sh_q[8:0], r_plain};
  assign r_sym_done = r_bit_stb & r_al_q & (r_c5_q == SYM_LAST);
  assign r_dec = fecp_dec(r_sh_d[4:0]);
  assign r_end = (r_sh_d[4:0] == SYM_T) | (r_sh_d[4:0] == SYM_I);
  assign n100_stb = r_sym_done & ~r_end;

  // every line edge re-centres the sampling phase
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r_lvl_q <= 2'h0;
      r_nrzi_q <= 1'b0;
      r_samp_q <= 1'b0;
      r_ph_q <= 8'h00;
    end
    else
    begin
      r_lvl_q <= {rxp_q[1], rxn_q[1]};
      r_nrzi_q <= r_nrzi_q ^ r_chg;
      r_ph_q <= (r_chg | (r_ph_q == OVS_LAST)) ? 8'h00 : r_ph_q + 8'h01;
      if (r_bit_stb)
        r_samp_q <= r_nrzi_q;
    end
  end

  // unlocked, the idle stream (all ones) is loaded as key history
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r_lock_q <= 1'b0;
      r_lcnt_q <= 6'h00;
    end
    else if (!mode_100)
    begin
      r_lock_q <= 1'b0;
      r_lcnt_q <= 6'h00;
    end
    else if (r_bit_stb & ~r_lock_q)
    begin
      if (r_key == ~r_nrz)
      begin
        r_lcnt_q <= r_lcnt_q + 6'h01;
        r_lock_q <= (r_lcnt_q == SCR_LOCK_CNT - 6'h01);
      end
      else
        r_lcnt_q <= 6'h00;
    end
  end

  fecp_lfsr u_rx_scr (
    .clk(CLK_SYS),
    .rst(RESET),
    .adv(r_bit_stb),
    .load(~r_lock_q),
    .load_bit(~r_nrz),
    .key(r_key)
  );

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r_sh_q <= 10'h000;
      r_al_q <= 1'b0;
      r_c5_q <= 3'h0;
    end
    else if (!mode_100 | !r_lock_q)
    begin
      r_al_q <= 1'b0;
      r_c5_q <= 3'h0;
    end
    else if (r_bit_stb)
    begin
      r_sh_q <= r_sh_d;
      if (!r_al_q & (r_sh_d == {SYM_J, SYM_K}))
      begin
        r_al_q <= 1'b1;
        r_c5_q <= 3'h0;
      end
      else if (r_sym_done)
      begin
        r_c5_q <= 3'h0;
        if (r_end)
          r_al_q <= 1'b0;
      end
      else if (r_al_q)
        r_c5_q <= r_c5_q + 3'h1;
    end
  end

  // receive, 10BASE-T
  logic r10_l_q;
  logic r10_t;
  logic [7:0] r10_pw_q;
  logic [7:0] r10_mc_q;
  logic [3:0] r10_sqc_q;
  logic r10_sq_open;
  logic r10_act_q;
  logic r10_loss;
  logic r10_bit_stb;
  logic r10_braw;
  logic r10_b;
  logic r10_sfd;
  logic r10_pb_q;
  logic [3:0] r10_alt_q;
  logic r10_pol_q;
  logic r10_pend_q;
  logic [3:0] r10_nib_q;
  logic [3:0] r10_nib_d;
  logic [1:0] r10_nc_q;
  logic n10_stb;
  logic [3:0] n10_dat;
  logic r10_nib_end;
  logic r10_flush;
  logic [3:0] r10_hold_q;
  fecp_r10_st_t r10_st_q;

  assign r10_t = mode_10 & (rxp_q[1] != r10_l_q);
  assign r10_sq_open = sq_q[1] & (r10_sqc_q == SQ_OPEN_PULSES);
  assign r10_loss = r10_act_q & ((r10_mc_q >= MAN_LOSS) | ~sq_q[1]);
  // only mid-bit edges count; cell-boundary edges fall inside the gate
  assign r10_bit_stb = r10_t & r10_sq_open & (~r10_act_q | (r10_mc_q >= MAN_GATE));
  assign r10_braw = rxp_q[1];
  assign r10_b = r10_braw ^ r10_pol_q;
  assign r10_sfd = (r10_st_q == R10_HUNT) & (r10_braw == r10_pb_q) & (r10_alt_q >= PRE_MIN_ALT);
  assign r10_nib_d = {r10_b, r10_nib_q[3:1]};
  assign r10_nib_end = (r10_st_q == R10_DATA) & (r10_nc_q == 2'h3);
  // the last held nibble leaves one nibble time after the final bit
  assign r10_flush = mode_10 & r10_pend_q & (r10_mc_q == R10_FLUSH);
  assign n10_stb = r10_flush | (r10_bit_stb & (r10_sfd | r10_nib_end));
  assign n10_dat = r10_sfd ? SFD_NIB_LO : r10_hold_q;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r10_l_q <= 1'b0;
      r10_pw_q <= 8'hFF;
      r10_mc_q <= 8'hFF;
      r10_sqc_q <= 4'h0;
      r10_act_q <= 1'b0;
    end
    else
    begin
      r10_l_q <= rxp_q[1];
      r10_pw_q <= r10_t ? 8'h00 : fecp_sat8(r10_pw_q);
      r10_mc_q <= r10_bit_stb ? 8'h00 : fecp_sat8(r10_mc_q);
      if (!sq_q[1])
        r10_sqc_q <= 4'h0;
      else if (r10_t)
      begin
        if (r10_pw_q < SQ_MIN_PW)
          r10_sqc_q <= 4'h0;
        else if (r10_sqc_q != SQ_OPEN_PULSES)
          r10_sqc_q <= r10_sqc_q + 4'h1;
      end
      if (!mode_10 | r10_loss)
        r10_act_q <= 1'b0;
      else if (r10_bit_stb)
        r10_act_q <= 1'b1;
    end
  end

  // polarity is learnt from the SFD's closing pair and kept across frames
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r10_st_q <= R10_HUNT;
      r10_pb_q <= 1'b0;
      r10_alt_q <= 4'h0;
      r10_pol_q <= 1'b0;
      r10_nib_q <= 4'h0;
      r10_nc_q <= 2'h0;
    end
    else if (!mode_10 | r10_loss)
    begin
      r10_st_q <= R10_HUNT;
      r10_alt_q <= 4'h0;
    end
    else if (r10_bit_stb)
    begin
      r10_pb_q <= r10_braw;
      case (r10_st_q)
        R10_HUNT:
          if (r10_braw != r10_pb_q)
            r10_alt_q <= (r10_alt_q == 4'hF) ? r10_alt_q : r10_alt_q + 4'h1;
          else
          begin
            if (r10_sfd)
            begin
              r10_pol_q <= ~r10_braw;
              r10_st_q <= R10_DATA;
              r10_nc_q <= 2'h0;
            end
            r10_alt_q <= 4'h0;
          end
        R10_DATA:
        begin
          r10_nib_q <= r10_nib_d;
          r10_nc_q <= r10_nc_q + 2'h1;
        end
        default:
          r10_st_q <= R10_HUNT;
      endcase
    end
  end

  // the delimiter needs two nibble slots but is only known at its last bit,
  // so every data nibble is held back one nibble time to keep the cadence
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      r10_hold_q <= 4'h0;
      r10_pend_q <= 1'b0;
    end
    else if (!mode_10)
      r10_pend_q <= 1'b0;
    else if (r10_bit_stb & r10_sfd)
    begin
      r10_hold_q <= SFD_NIB_HI;
      r10_pend_q <= 1'b1;
    end
    else if (r10_bit_stb & r10_nib_end)
      r10_hold_q <= r10_nib_d;
    else if (r10_flush)
      r10_pend_q <= 1'b0;
  end

  // mac receive port; one-deep staging assumes nominal rates match
  logic [7:0] rck_cnt_q;
  logic [7:0] rck_half;
  logic rck_q;
  logic rck_wrap;
  logic rx_upd;
  logic n_stb;
  logic [4:0] stg_q;
  logic stg_v_q;
  logic [3:0] rxd_q;
  logic rx_dv_q;
  logic rx_er_q;
  logic gig_q;

  assign rck_half = mode_100 ? RCK_HALF_100 : RCK_HALF_10;
  assign rck_wrap = (rck_cnt_q >= rck_half);
  assign rx_upd = rck_wrap & rck_q;
  assign n_stb = n100_stb | n10_stb;

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      rck_cnt_q <= 8'h00;
      rck_q <= 1'b0;
      stg_q <= 5'h00;
      stg_v_q <= 1'b0;
      rxd_q <= 4'h0;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
    end
    else
    begin
      rck_cnt_q <= rck_wrap ? 8'h00 : rck_cnt_q + 8'h01;
      if (rck_wrap)
        rck_q <= ~rck_q;
      if (n_stb)
        stg_q <= mode_100 ? {~r_dec[4], r_dec[3:0]} : {1'b0, n10_dat};
      if (n_stb)
        stg_v_q <= 1'b1;
      else if (rx_upd)
        stg_v_q <= 1'b0;
      if (rx_upd)
      begin
        rxd_q <= stg_q[3:0];
        rx_dv_q <= stg_v_q;
        rx_er_q <= stg_v_q & stg_q[4];
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
      gig_q <= 1'b0;
    else
      gig_q <= (SPEED == SPEED_1000);
  end

  assign RX_CLK = rck_q;
  assign RXD = rxd_q;
  assign RX_DV = rx_dv_q;
  assign RX_ER = rx_er_q;
  assign RX_POL_INV = r10_pol_q;
  assign ECHO_CANCEL_EN = gig_q;
  assign ADC_EN = gig_q;

endmodule

/* File: rtl/fecp_pkg.sv */
// Notes on behaviour
// - serialize MAC nibbles at line bit rate
// - 4B/5B encode, then scramble transmit stream
// - scrambled bits go NRZI, then MLT-3 out
// - 11-bit LFSR scrambler, 100BASE-TX only
// - 2047-bit sequence, same sequence descrambles receive
// - receive MLT-3 levels become NRZI stream
// - recover bit clock from NRZI edges, NRZI-to-NRZ
// - descramble first, then 4B/5B decode
// - decoded nibbles delivered to MAC receive port
// - Manchester stream split into clock and NRZ
// - decode only after squelch opens, ignore glitches
// - receive clock keeps running between frames
// - strip 7 preamble bytes, start at SFD
// - detect reversed 10BASE-T pair, invert polarity
// - echo-cancel and ADC off in 10/100
package fecp_pkg;

  // speed selection codes
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  localparam int CLK_SYS_MHZ = 100;
  // the transmit line clock input carries this rate in silicon
  localparam int LINE_RATE_MHZ = 125;
  // receive oversampling per code bit; bench-scaled default
  localparam int RX_OVS_DEF = 16;
  localparam int SYM_BITS = 5;

  // scrambler x^11 + x^9 + 1
  localparam int SCR_WIDTH = 11;
  localparam int SCR_TAP_HI = 10;
  localparam int SCR_TAP_LO = 8;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  localparam logic [5:0] SCR_LOCK_CNT = 6'h1E;

  // control code groups, first transmitted bit is bit 4
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_I = 5'h1F;
  localparam logic [4:0] SYM_H = 5'h04;

  // 10BASE-T timing
  localparam int T10_BIT_NS = 100;
  localparam int T10_BIT_CYC = (T10_BIT_NS * CLK_SYS_MHZ) / 1000;
  localparam int MAN_GATE_CYC = (T10_BIT_CYC * 3) / 4;
  localparam int MAN_LOSS_CYC = T10_BIT_CYC * 2;
  localparam int SQ_MIN_PW_NS = 30;
  localparam int SQ_MIN_PW_CYC = (SQ_MIN_PW_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int T10_NIB_HALF_CYC = T10_BIT_CYC * 2;
  localparam logic [3:0] SQ_OPEN_PULSES = 4'h8;
  localparam logic [3:0] PRE_MIN_ALT = 4'hC;
  localparam logic [3:0] SFD_NIB_LO = 4'h5;
  localparam logic [3:0] SFD_NIB_HI = 4'hD;

  typedef enum {TX_IDLE, TX_SK, TX_DATA, TX_END} fecp_tx_st_t;
  typedef enum {R10_HUNT, R10_DATA} fecp_r10_st_t;

  function automatic logic [7:0] fecp_sat8(input logic [7:0] v);
    logic [7:0] r;
    r = (v == 8'hFF) ? v : v + 8'h01;
    return r;
  endfunction

  function automatic logic [4:0] fecp_enc(input logic [3:0] nib);
    logic [4:0] code;
    case (nib)
      4'h0: code = 5'h1E;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0A;
      4'h5: code = 5'h0B;
      4'h6: code = 5'h0E;
      4'h7: code = 5'h0F;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'hA: code = 5'h16;
      4'hB: code = 5'h17;
      4'hC: code = 5'h1A;
      4'hD: code = 5'h1B;
      4'hE: code = 5'h1C;
      default: code = 5'h1D;
    endcase
    return code;
  endfunction

  // returns {valid, nibble}
  function automatic logic [4:0] fecp_dec(input logic [4:0] code);
    logic [4:0] r;
    case (code)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

endpackage

/* File: rtl/fecp_lfsr.sv */
`timescale 1ns/1ps
module fecp_lfsr (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequence control
  input wire logic adv,
  input wire logic load,
  input wire logic load_bit,
  // key bit for the current line bit
  output logic key
);
  import fecp_pkg::*;

  logic [SCR_WIDTH-1:0] lfsr_q;

  assign key = lfsr_q[SCR_TAP_HI] ^ lfsr_q[SCR_TAP_LO];

  // load lets the receiver pull its state from the idle stream
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lfsr_q <= SCR_SEED;
    else if (adv)
      lfsr_q <= {lfsr_q[SCR_WIDTH-2:0], load ? load_bit : key};
  end

endmodule

/* File: bench/fecp_chk.sv */
`timescale 1ns/1ps
module fecp_chk #(
  parameter int RX_OVS = 16
) (
  // system
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [1:0] SPEED,
  // transmit
  input wire logic TX_NIB_TAKE,
  input wire logic TX_LINE_POS,
  input wire logic TX_LINE_NEG,
  // receive
  input wire logic RX_CLK,
  input wire logic [3:0] RXD,
  input wire logic RX_DV,
  input wire logic RX_ER,
  // gigabit stages
  input wire logic ECHO_CANCEL_EN,
  input wire logic ADC_EN
);
  import fecp_pkg::*;
  // slack of 3 cycles over the 100-mode half period, the longest one
  localparam int MAX_HALF = (RX_OVS * 5) / 2 + 3;
  logic rx_clk_q;
  logic [7:0] still_q;
  logic [7:0] still_d;
  assign still_d = (RX_CLK != rx_clk_q) ? 8'h00 : (still_q == 8'hFF) ? still_q : still_q + 8'h01;
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      rx_clk_q <= 1'b0;
      still_q <= 8'h00;
    end
    else
    begin
      rx_clk_q <= RX_CLK;
      still_q <= still_d;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  chk_gig_on: assert property (SPEED == SPEED_1000 |=> ECHO_CANCEL_EN)
    else $error("echo cancel off in gigabit mode");
  chk_gig_off: assert property (SPEED != SPEED_1000 |=> !ECHO_CANCEL_EN && !ADC_EN)
    else $error("gigabit stage enabled in 10/100 mode");
  chk_adc_follows: assert property (ADC_EN == ECHO_CANCEL_EN)
    else $error("adc enable differs from echo cancel enable");
  chk_mlt_exclusive: assert property (!(TX_LINE_POS && TX_LINE_NEG))
    else $error("both line levels driven");
  chk_mlt_step: assert property ($changed({TX_LINE_POS, TX_LINE_NEG}) |->
    $past({TX_LINE_POS, TX_LINE_NEG}) == 2'b00 || {TX_LINE_POS, TX_LINE_NEG} == 2'b00)
    else $error("line jumped between outer levels");
  chk_line_quiet: assert property (SPEED != SPEED_100 ##1 SPEED != SPEED_100 |->
    !TX_LINE_POS && !TX_LINE_NEG)
    else $error("line driven outside 100 mode");
  chk_take_mode: assert property (TX_NIB_TAKE |-> SPEED == SPEED_100)
    else $error("nibble taken outside 100 mode");
  chk_take_gap: assert property (TX_NIB_TAKE |=> !TX_NIB_TAKE [*8])
    else $error("nibble takes too close");
  chk_err_dv: assert property (RX_ER |-> RX_DV)
    else $error("receive error without data valid");
  chk_rxd_fall: assert property (!$stable({RXD, RX_DV, RX_ER}) |-> $fell(RX_CLK))
    else $error("receive data moved off the clock fall");
  chk_clk_alive: assert property (still_q <= MAX_HALF)
    else $error("receive clock stopped");
endmodule

bind fecp_top fecp_chk #(.RX_OVS(RX_OVS)) fecp_chk_inst (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .SPEED(SPEED), .TX_NIB_TAKE(TX_NIB_TAKE),
  .TX_LINE_POS(TX_LINE_POS), .TX_LINE_NEG(TX_LINE_NEG), .RX_CLK(RX_CLK), .RXD(RXD),
  .RX_DV(RX_DV), .RX_ER(RX_ER), .ECHO_CANCEL_EN(ECHO_CANCEL_EN), .ADC_EN(ADC_EN)
);

/* File: bench/fecp_mac_model.sv */
`timescale 1ns/1ps
module fecp_mac_model (
  // system clock
  input wire logic clk,
  // transmit nibbles toward the coding path
  input wire logic tx_nib_take,
  output logic tx_en,
  output logic tx_er,
  output logic [3:0] txd,
  // receive nibbles from the coding path
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er
);
  // entries are {error, nibble}; the head stays on txd until taken
  logic [4:0] txq[$];
  logic [4:0] rxq[$];
  logic took_q = 1'b0;
  initial
  begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
  end
  always @(posedge clk)
    took_q <= tx_nib_take;
  // dropping tx_en once the queue runs dry is what closes the frame
  always @(negedge clk)
  begin
    if (took_q && txq.size() > 0)
      void'(txq.pop_front());
    tx_en = (txq.size() > 0);
    if (txq.size() > 0)
      {tx_er, txd} = txq[0];
  end
  always @(posedge rx_clk)
    if (rx_dv)
      rxq.push_back({rx_er, rxd});
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import fecp_pkg::*;
  logic clk_sys, reset, tx_line_clk, squelch, line10_q;
  logic [1:0] speed;
  logic tx_en, tx_er, tx_nib_take, tx_pos, tx_neg, rx_pos, rx_neg;
  logic [3:0] txd;
  logic [3:0] rxd;
  logic rx_clk, rx_dv, rx_er, rx_pol_inv, echo_en, adc_en;
  logic [4:0] exp_q[$];
  int fails = 0;
  int comparisons = 0;
  // 100 mode loops the line back so the receive path sees our own transmit
  assign rx_pos = (speed == SPEED_100) ? tx_pos : line10_q;
  assign rx_neg = (speed == SPEED_100) ? tx_neg : 1'b0;
  fecp_top #(.RX_OVS(16)) fecp_top_inst (
    .CLK_SYS(clk_sys), .RESET(reset), .SPEED(speed), .TX_EN(tx_en), .TX_ER(tx_er),
    .TXD(txd), .TX_NIB_TAKE(tx_nib_take), .TX_LINE_CLK(tx_line_clk), .TX_LINE_POS(tx_pos),
    .TX_LINE_NEG(tx_neg), .RX_LINE_POS(rx_pos), .RX_LINE_NEG(rx_neg), .SQUELCH_LVL(squelch),
    .RX_CLK(rx_clk), .RXD(rxd), .RX_DV(rx_dv), .RX_ER(rx_er), .RX_POL_INV(rx_pol_inv),
    .ECHO_CANCEL_EN(echo_en), .ADC_EN(adc_en)
  );
  fecp_mac_model fecp_mac_model_inst (
    .clk(clk_sys), .tx_nib_take(tx_nib_take), .tx_en(tx_en), .tx_er(tx_er), .txd(txd),
    .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    tx_line_clk = 1'b0;
    #3;
    forever #80 tx_line_clk = ~tx_line_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // rising edges of rx_clk, or any step of the line level
  task automatic count_ev(input logic line, input int ncyc, input int exp);
    int n;
    logic [1:0] prev;
    logic [1:0] now;
    n = 0;
    prev = line ? {tx_pos, tx_neg} : {1'b0, rx_clk};
    repeat (ncyc)
    begin
      @(negedge clk_sys);
      now = line ? {tx_pos, tx_neg} : {1'b0, rx_clk};
      if (now != prev && (line || now[0]))
        n++;
      prev = now;
    end
    check(32'(n), 32'(exp));
  endtask
  // an error entry only pins the error flag; its nibble is undefined
  task automatic fin_rx();
    int i;
    logic [4:0] m;
    for (i = 0; i < 8000 && fecp_mac_model_inst.rxq.size() < exp_q.size(); i++)
      @(negedge clk_sys);
    if (i == 8000)
    begin
      fails++;
      close_out();
    end
    repeat (200) @(negedge clk_sys);
    check(32'(fecp_mac_model_inst.rxq.size()), 32'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < fecp_mac_model_inst.rxq.size(); i++)
    begin
      m = exp_q[i][4] ? 5'h10 : 5'h1F;
      check(32'(fecp_mac_model_inst.rxq[i] & m), 32'(exp_q[i] & m));
    end
  endtask
  task automatic run100(input int len, input int bad);
    int k;
    exp_q.delete();
    fecp_mac_model_inst.rxq.delete();
    fecp_mac_model_inst.txq.push_back(5'h05);
    fecp_mac_model_inst.txq.push_back(5'h05);
    for (k = 0; k < len; k++)
    begin
      exp_q.push_back({1'(k == bad), 4'($urandom)});
      fecp_mac_model_inst.txq.push_back(exp_q[k]);
    end
    fin_rx();
  endtask
  // each bit is 10 cycles, level ~v then v; preamble, delimiter, then data
  task automatic send10(input int nbytes, input logic inv, input logic sq);
    logic [7:0] b;
    int i;
    int j;
    exp_q = '{5'h05, 5'h0D};
    fecp_mac_model_inst.rxq.delete();
    squelch = sq;
    for (i = 0; i < 8 + nbytes; i++)
    begin
      b = (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : 8'($urandom);
      if (i > 7)
        exp_q.push_back({1'b0, b[3:0]});
      if (i > 7)
        exp_q.push_back({1'b0, b[7:4]});
      for (j = 0; j < 8; j++)
      begin
        line10_q = ~(b[j] ^ inv);
        repeat (5) @(negedge clk_sys);
        line10_q = b[j] ^ inv;
        repeat (5) @(negedge clk_sys);
      end
    end
    squelch = 1'b0;
    if (!sq)
      exp_q.delete();
    fin_rx();
  endtask
  initial
  begin
    int s;
    reset = 1'b1;
    speed = SPEED_10;
    squelch = 1'b0;
    line10_q = 1'b0;
    void'($urandom(32'h1F71));
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    for (s = 0; s < 4; s++)
    begin
      speed = 2'(s);
      repeat (3) @(negedge clk_sys);
      check(32'(echo_en), 32'(s == 2));
      check(32'(adc_en), 32'(s == 2));
    end
    speed = SPEED_10;
    repeat (60) @(negedge clk_sys);
    count_ev(1'b0, 400, 10);
    speed = SPEED_100;
    repeat (100) @(negedge clk_sys);
    count_ev(1'b0, 400, 5);
    // idle ones scrambled over one full sequence step the line 1023 times
    count_ev(1'b1, 2047 * 16, 1023);
    run100(8 + 32'($urandom % 8), 3);
    run100(1, -1);
    speed = SPEED_10;
    repeat (100) @(negedge clk_sys);
    send10(6, 1'b0, 1'b1);
    check(32'(rx_pol_inv), 32'h0);
    send10(4 + 32'($urandom % 4), 1'b1, 1'b1);
    check(32'(rx_pol_inv), 32'h1);
    send10(3, 1'b0, 1'b0);
    // pulses too short for the squelch must never open a frame
    exp_q.delete();
    squelch = 1'b1;
    repeat (40)
    begin
      line10_q = ~line10_q;
      repeat (2) @(negedge clk_sys);
    end
    squelch = 1'b0;
    fin_rx();
    close_out();
  end
endmodule
